/* File: hdl/sebl_pkg.sv */
// Constants shared by the serial boot loader
`default_nettype none
package sebl_pkg;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] START_ADDR = 8'h00;
    localparam int CMD_BYTES = 2;
    localparam logic [15:0] FLAG_LOAD_PM = 16'h0000;
    localparam logic [15:0] FLAG_FILL_PM = 16'h0004;
    localparam logic [15:0] FLAG_FINAL = 16'h0007;
    localparam logic [1:0] MODE_SERIAL = 2'h1;
    localparam logic [15:0] WAIT_DM_ADDR = 16'hff00;
    localparam logic [15:0] WIDTH_DM_ADDR = 16'hff01;
    localparam logic [15:0] HDR_DM_BASE = 16'hff02;
    localparam logic [15:0] EXEC_ADDR = 16'h0000;
    localparam int LINK_PERIOD_NS = 125;
    localparam int BIT_RATE_HZ = 122000;
    localparam int SCK_HALF_CYCLES = 1000000000 / (2 * BIT_RATE_HZ * LINK_PERIOD_NS);
    localparam logic [5:0] SCK_HALF_LAST = 6'(SCK_HALF_CYCLES - 1);
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] MODE_SETTLE = 3'h2;
    localparam int FIFO_DEPTH = 16;
endpackage : sebl_pkg
`default_nettype wire

/* File: hdl/sebl_loader.sv */
// Serial boot loader: link shifter, byte FIFO and boot image unpacker
`default_nettype none

module sebl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } sebl_fifo_type;
    sebl_fifo_type r, next_r;
    logic push, pop;

    assign in_ready_o = r.count != (AW + 1)'(DEPTH);
    assign out_valid_o = r.count != '0;
    assign out_data_o = r.mem[r.rd];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_ready_i && out_valid_o;

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wr] = in_data_i;
            next_r.wr = (r.wr == AW'(DEPTH - 1)) ? '0 : r.wr + 1'b1;
        end
        if (pop) begin
            next_r.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + 1'b1;
        end
        next_r.count = r.count + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule : sebl_fifo

module sebl_loader (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic boot_mode_pin_low_i,
    input wire logic boot_mode_pin_high_i,
    output logic spi_sck_o,
    output logic spi_mosi_o,
    input wire logic spi_miso_i,
    output logic boot_device_select_n_o,
    output logic mem_we_o,
    output logic mem_pm_o,
    output logic [15:0] mem_page_o,
    output logic [15:0] mem_addr_o,
    output logic [23:0] mem_data_o,
    input wire logic mem_ready_i,
    output logic boot_busy_o,
    output logic exec_start_o,
    output logic [15:0] exec_addr_o
);
    import sebl_pkg::*;

    typedef enum logic [3:0] {
        ST_SAMPLE, ST_OFF, ST_WAIT, ST_WIDTH, ST_HDR, ST_PAYLOAD, ST_FILL,
        ST_FINISH, ST_RUN
    } sebl_state_type;
    typedef struct packed {
        logic en_s1, en_s2;
        logic req_s1, req_s2, req_s3;
        logic miso_s1, miso_s2;
        logic cs_n, sck, mosi, busy;
        logic [5:0] div;
        logic [2:0] bitn;
        logic [7:0] tx, rx, rx_hold;
        logic [1:0] sent;
        logic ack;
    } sebl_link_type;
    typedef struct packed {
        sebl_state_type state;
        logic [1:0] mode_s1, mode_s2;
        logic [2:0] settle;
        logic ack_s1, ack_s2, ack_s3;
        logic req, pend, en;
        logic [1:0] skip;
        logic [2:0] idx;
        logic [7:0] lo;
        logic [15:0] flag, addr, page, left;
        logic [1:0] ibyte;
        logic [15:0] ins;
        logic we, pm;
        logic [15:0] w_page, w_addr;
        logic [23:0] w_data;
        logic busy, exec;
        logic [15:0] jump;
    } sebl_core_type;

    sebl_link_type l, next_l;
    sebl_core_type c, next_c;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready, take;
    logic [7:0] fifo_out_data;
    logic [15:0] word;

    // Link side: byte shifter clocked from the link clock
    always_comb begin
        next_l = l;
        next_l.en_s1 = c.en;
        next_l.en_s2 = l.en_s1;
        next_l.req_s1 = c.req;
        next_l.req_s2 = l.req_s1;
        next_l.req_s3 = l.req_s2;
        next_l.miso_s1 = spi_miso_i;
        next_l.miso_s2 = l.miso_s1;
        if (!l.busy) begin
            next_l.cs_n = !l.en_s2;
            next_l.sck = 1'b0;
            if (!l.en_s2) begin
                next_l.sent = '0;
            end
            if (l.en_s2 && (l.req_s2 != l.req_s3)) begin
                next_l.tx = (l.sent == 2'h0) ? CMD_READ : START_ADDR;
                next_l.mosi = next_l.tx[7];
                next_l.busy = 1'b1;
                next_l.div = '0;
                next_l.bitn = '0;
            end
        end else if (l.div == SCK_HALF_LAST) begin
            next_l.div = '0;
            next_l.sck = !l.sck;
            if (l.sck) begin
                // Falling edge: take the bit seen at the rising edge, then shift
                next_l.rx = {l.rx[6:0], l.miso_s2};
                if (l.bitn == BIT_LAST) begin
                    next_l.rx_hold = {l.rx[6:0], l.miso_s2};
                    next_l.ack = !l.ack;
                    next_l.busy = 1'b0;
                    next_l.mosi = 1'b0;
                    if (l.sent != 2'(CMD_BYTES)) begin
                        next_l.sent = l.sent + 2'h1;
                    end
                end else begin
                    next_l.tx = {l.tx[6:0], 1'b0};
                    next_l.mosi = l.tx[6];
                    next_l.bitn = l.bitn + 3'h1;
                end
            end
        end else begin
            next_l.div = l.div + 6'h1;
        end
    end

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            l <= '{cs_n: 1'b1, default: '0};
        end else begin
            l <= next_l;
        end
    end

    sebl_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i(l.rx_hold),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_out_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready)
    );

    // Received byte is stable in rx_hold until the next request is seen
    assign fifo_in_valid = (c.ack_s2 != c.ack_s3) && (c.skip == 2'h0);
    assign fifo_out_ready = !c.we && (c.state == ST_WAIT || c.state == ST_WIDTH ||
        c.state == ST_HDR || c.state == ST_PAYLOAD);
    assign take = fifo_out_ready && fifo_out_valid;
    assign word = {fifo_out_data, c.lo};

    // Core side: request pacing and image unpacking
    always_comb begin
        next_c = c;
        next_c.mode_s1 = {boot_mode_pin_high_i, boot_mode_pin_low_i};
        next_c.mode_s2 = c.mode_s1;
        next_c.ack_s1 = l.ack;
        next_c.ack_s2 = c.ack_s1;
        next_c.ack_s3 = c.ack_s2;
        if (c.ack_s2 != c.ack_s3) begin
            next_c.pend = 1'b0;
            if (c.skip != 2'h0) begin
                next_c.skip = c.skip - 2'h1;
            end
        end
        // Back-pressure: a byte is asked for only while the FIFO has room
        if (c.en && !c.pend && fifo_in_ready && c.state != ST_FINISH) begin
            next_c.req = !c.req;
            next_c.pend = 1'b1;
        end
        if (c.we && mem_ready_i) begin
            next_c.we = 1'b0;
        end
        case (c.state)
            ST_SAMPLE: begin
                next_c.settle = c.settle + 3'h1;
                if (c.settle == MODE_SETTLE) begin
                    if (c.mode_s2 == MODE_SERIAL) begin
                        next_c.en = 1'b1;
                        next_c.busy = 1'b1;
                        next_c.state = ST_WAIT;
                    end else begin
                        next_c.state = ST_OFF;
                    end
                end
            end
            ST_WAIT, ST_WIDTH: begin
                if (take) begin
                    next_c.we = 1'b1;
                    next_c.pm = 1'b0;
                    next_c.w_page = '0;
                    next_c.w_addr = (c.state == ST_WAIT) ? WAIT_DM_ADDR : WIDTH_DM_ADDR;
                    next_c.w_data = {16'h0000, fifo_out_data};
                    next_c.idx = '0;
                    next_c.state = (c.state == ST_WAIT) ? ST_WIDTH : ST_HDR;
                end
            end
            ST_HDR: begin
                if (take) begin
                    next_c.idx = c.idx + 3'h1;
                    if (!c.idx[0]) begin
                        next_c.lo = fifo_out_data;
                    end else begin
                        next_c.we = 1'b1;
                        next_c.pm = 1'b0;
                        next_c.w_page = '0;
                        next_c.w_addr = HDR_DM_BASE + 16'(c.idx[2:1]);
                        next_c.w_data = {8'h00, word};
                        case (c.idx[2:1])
                            2'h0: next_c.flag = word;
                            2'h1: next_c.addr = word;
                            2'h2: next_c.page = word;
                            default: begin
                                next_c.left = word;
                                next_c.ibyte = '0;
                                if (word == 16'h0000) begin
                                    next_c.state = (c.flag == FLAG_FINAL) ? ST_FINISH : ST_HDR;
                                end else if (c.flag == FLAG_LOAD_PM) begin
                                    next_c.state = ST_PAYLOAD;
                                end else begin
                                    next_c.state = ST_FILL;
                                end
                            end
                        endcase
                    end
                end
            end
            ST_PAYLOAD: begin
                if (take) begin
                    next_c.ibyte = (c.ibyte == 2'h2) ? 2'h0 : c.ibyte + 2'h1;
                    if (c.ibyte == 2'h0) begin
                        next_c.ins[7:0] = fifo_out_data;
                    end else if (c.ibyte == 2'h1) begin
                        next_c.ins[15:8] = fifo_out_data;
                    end else begin
                        next_c.we = 1'b1;
                        next_c.pm = 1'b1;
                        next_c.w_page = c.page;
                        next_c.w_addr = c.addr;
                        next_c.w_data = {fifo_out_data, c.ins};
                        next_c.addr = c.addr + 16'h1;
                        next_c.left = c.left - 16'h1;
                        if (c.left == 16'h1) begin
                            next_c.idx = '0;
                            next_c.state = ST_HDR;
                        end
                    end
                end
            end
            ST_FILL: begin
                if (!c.we) begin
                    next_c.we = 1'b1;
                    next_c.pm = (c.flag == FLAG_FILL_PM);
                    next_c.w_page = c.page;
                    next_c.w_addr = c.addr;
                    next_c.w_data = '0;
                    next_c.addr = c.addr + 16'h1;
                    next_c.left = c.left - 16'h1;
                    if (c.left == 16'h1) begin
                        next_c.idx = '0;
                        next_c.state = (c.flag == FLAG_FINAL) ? ST_FINISH : ST_HDR;
                    end
                end
            end
            ST_FINISH: begin
                // Last write retired and no byte in flight before the port drops
                if (!c.pend && !c.we) begin
                    next_c.en = 1'b0;
                    next_c.state = ST_RUN;
                end
            end
            ST_RUN: begin
                next_c.busy = 1'b0;
                next_c.jump = EXEC_ADDR;
                next_c.exec = 1'b1;
            end
            ST_OFF: begin
                next_c.busy = 1'b0;
            end
            default: begin
                next_c.state = ST_SAMPLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            c <= '{state: ST_SAMPLE, skip: 2'(CMD_BYTES), default: '0};
        end else begin
            c <= next_c;
        end
    end

    assign spi_sck_o = l.sck;
    assign spi_mosi_o = l.mosi;
    assign boot_device_select_n_o = l.cs_n;
    assign mem_we_o = c.we;
    assign mem_pm_o = c.pm;
    assign mem_page_o = c.w_page;
    assign mem_addr_o = c.w_addr;
    assign mem_data_o = c.w_data;
    assign boot_busy_o = c.busy;
    assign exec_start_o = c.exec;
    assign exec_addr_o = c.jump;
endmodule : sebl_loader
`default_nettype wire

/* File: test/sebl_loader_props.sv */
// Port checker for the serial boot loader
`default_nettype none
module sebl_loader_props
    import sebl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic spi_sck_o,
    input wire logic spi_mosi_o,
    input wire logic boot_device_select_n_o,
    input wire logic mem_we_o,
    input wire logic mem_pm_o,
    input wire logic [15:0] mem_page_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic [23:0] mem_data_o,
    input wire logic mem_ready_i,
    input wire logic boot_busy_o,
    input wire logic exec_start_o,
    input wire logic [15:0] exec_addr_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] hi_len;
    logic [4:0] rises;
    logic sck_q;
    // Length of the current high phase and rising edges seen in this frame, held at 16
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hi_len <= 6'h00;
            rises <= 5'h00;
            sck_q <= 1'b0;
        end else begin
            sck_q <= spi_sck_o;
            hi_len <= spi_sck_o ? hi_len + 6'h01 : 6'h00;
            if (boot_device_select_n_o) begin
                rises <= 5'h00;
            end else if (spi_sck_o && !sck_q && rises != 5'h10) begin
                rises <= rises + 5'h01;
            end
        end
    end
    sequence wr_wait;
        mem_we_o && !mem_ready_i;
    endsequence
    sequence wr_take;
        mem_we_o && mem_ready_i;
    endsequence
    sck_idle_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        boot_device_select_n_o |-> !spi_sck_o) else $error("clock moves while deselected");
    mosi_setup_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $rose(spi_sck_o) |-> $stable(spi_mosi_o)) else $error("data changed on rising clock");
    half_period_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $fell(spi_sck_o) |-> hi_len == 6'(SCK_HALF_CYCLES)) else $error("clock high phase length");
    mosi_low_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $rose(spi_sck_o) && rises == 5'h10 |-> !spi_mosi_o) else $error("data out not low");
    we_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) wr_wait |=>
        mem_we_o && $stable(mem_addr_o) && $stable(mem_data_o) && $stable(mem_pm_o)
        && $stable(mem_page_o)) else $error("write request not held");
    we_retire_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take |=> !mem_we_o) else $error("write request not retired");
    exec_state_a: assert property (@(posedge clk_i) disable iff (rst_i)
        exec_start_o |-> exec_addr_o == EXEC_ADDR && !boot_busy_o && !mem_we_o)
        else $error("execution start state wrong");
    exec_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        exec_start_o |=> exec_start_o) else $error("execution start dropped");
    port_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(exec_start_o) |-> ##[0:40] boot_device_select_n_o) else $error("port left on");
    busy_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mem_we_o |-> boot_busy_o) else $error("write outside boot");
endmodule : sebl_loader_props
bind sebl_loader sebl_loader_props chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .link_clk_i(link_clk_i), .spi_sck_o(spi_sck_o), .spi_mosi_o(spi_mosi_o),
    .boot_device_select_n_o(boot_device_select_n_o), .mem_we_o(mem_we_o),
    .mem_pm_o(mem_pm_o), .mem_page_o(mem_page_o), .mem_addr_o(mem_addr_o),
    .mem_data_o(mem_data_o), .mem_ready_i(mem_ready_i), .boot_busy_o(boot_busy_o),
    .exec_start_o(exec_start_o), .exec_addr_o(exec_addr_o));
`default_nettype wire

/* File: test/sebl_eeprom_model.sv */
// Behavioural serial EEPROM holding the boot image
`default_nettype none
module sebl_eeprom_model (
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic select_n_i,
    output logic miso_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:255];
    logic [15:0] cmd_word;
    logic [7:0] rd_byte;
    int rises;
    initial begin
        miso_o = 1'b1;
        rises = 0;
        cmd_word = 16'h0000;
        foreach (mem[i]) mem[i] = 8'hff;
    end
    always @(negedge select_n_i) begin
        rises = 0;
        cmd_word = 16'h0000;
    end
    // Line is pulled up while the part is deselected
    always @(posedge select_n_i) miso_o = 1'b1;
    always @(posedge sck_i) begin
        if (!select_n_i) begin
            if (rises < 16) cmd_word = {cmd_word[14:0], mosi_i};
            rises++;
        end
    end
    // Data changes on the falling edge, address advances on its own
    always @(negedge sck_i) begin
        if (!select_n_i && rises >= 16) begin
            rd_byte = mem[8'(cmd_word[7:0] + (rises - 16) / 8)];
            if (cmd_word[15:8] != 8'h03) rd_byte = 8'hff;
            miso_o = rd_byte[7 - (rises - 16) % 8];
        end
    end
endmodule : sebl_eeprom_model
`default_nettype wire

/* File: test/sebl_loader_tb_top.sv */
// Self-checking bench for the serial boot loader
`default_nettype none
module sebl_loader_tb_top
    import sebl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic pm;
        logic [15:0] page;
        logic [15:0] addr;
        logic [23:0] data;
    } sebl_wr_type;
    logic clk_i, rst_i, link_clk_i, mode_lo, mode_hi, sck, mosi, miso, sel_n;
    logic we, pm, ready, busy, exec, rdy_en;
    logic [15:0] page, addr, exec_addr;
    logic [23:0] data;
    logic [7:0] img [$];
    sebl_wr_type exp_q [$];
    sebl_wr_type got_q [$];
    int err_total = 0;
    int total_checks = 0;
    sebl_loader dut_u (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
        .boot_mode_pin_low_i(mode_lo), .boot_mode_pin_high_i(mode_hi), .spi_sck_o(sck),
        .spi_mosi_o(mosi), .spi_miso_i(miso), .boot_device_select_n_o(sel_n),
        .mem_we_o(we), .mem_pm_o(pm), .mem_page_o(page), .mem_addr_o(addr),
        .mem_data_o(data), .mem_ready_i(ready), .boot_busy_o(busy),
        .exec_start_o(exec), .exec_addr_o(exec_addr));
    sebl_eeprom_model eep_u (.sck_i(sck), .mosi_i(mosi), .select_n_i(sel_n), .miso_o(miso));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        link_clk_i = 1'b0;
        #37;
        forever #62.5 link_clk_i = ~link_clk_i;
    end
    // Accepted writes are logged; the memory stalls while rdy_en is low, then on every other cycle
    always @(posedge clk_i) begin
        if (!rst_i && we && ready) got_q.push_back({pm, pm ? page : 16'h0000, addr, data});
        ready <= #2 rdy_en && !ready;
    end
    task automatic check_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask : check_bit
    task automatic check_val(input string what, input logic [56:0] exp, input logic [56:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic put16(input logic [15:0] v);
        img.push_back(v[7:0]);
        img.push_back(v[15:8]);
    endtask : put16
    task automatic expect_wr(input logic p, input logic [15:0] pg, a, input logic [23:0] d);
        exp_q.push_back({p, p ? pg : 16'h0000, a, d});
    endtask : expect_wr
    task automatic block(input logic [15:0] flag, a, pg, n);
        logic [15:0] w [4];
        w = '{flag, a, pg, n};
        for (int k = 0; k < 4; k++) begin
            put16(w[k]);
            expect_wr(1'b0, 16'h0000, HDR_DM_BASE + 16'(k), {8'h00, w[k]});
        end
        for (int i = 0; flag != FLAG_LOAD_PM && i < n; i++) begin
            expect_wr(flag == FLAG_FILL_PM, pg, a + 16'(i), 24'h000000);
        end
    endtask : block
    task automatic do_reset(input logic [1:0] mode);
        @(posedge clk_i);
        #2;
        rst_i = 1'b1;
        {mode_hi, mode_lo} = mode;
        repeat (10) @(posedge clk_i);
        #2;
        rst_i = 1'b0;
    endtask : do_reset
    task automatic mode_off_test();
        do_reset(2'b10);
        repeat (400) @(posedge clk_i);
        #2;
        check_bit("select_n", 1'b1, sel_n);
        check_bit("busy", 1'b0, busy);
        check_val("clock edges", 57'h0, 57'(eep_u.rises));
    endtask : mode_off_test
    task automatic boot_test();
        int r0;
        img.push_back(8'h2f);
        img.push_back(8'h00);
        expect_wr(1'b0, 16'h0000, WAIT_DM_ADDR, 24'h00002f);
        expect_wr(1'b0, 16'h0000, WIDTH_DM_ADDR, 24'h000000);
        block(FLAG_LOAD_PM, 16'h0005, 16'h0002, 16'h0001);
        img.push_back(8'haa);
        img.push_back(8'hbb);
        img.push_back(8'hcc);
        expect_wr(1'b1, 16'h0002, 16'h0005, 24'hccbbaa);
        block(FLAG_FILL_PM, 16'h0010, 16'h0000, 16'h0002);
        block(FLAG_FINAL, 16'hfef0, 16'h0000, 16'h0002);
        foreach (img[i]) eep_u.mem[i] = img[i];
        do_reset(MODE_SERIAL);
        repeat (40) @(posedge clk_i);
        #2;
        check_bit("busy", 1'b1, busy);
        check_bit("select_n", 1'b0, sel_n);
        // Memory held off so the byte buffer fills and the link pauses
        repeat (49960) @(posedge clk_i);
        r0 = eep_u.rises;
        repeat (1000) @(posedge clk_i);
        check_val("paused clock edges", 57'(r0), 57'(eep_u.rises));
        check_val("edges before pause", 57'(8 * (CMD_BYTES + 1 + FIFO_DEPTH)), 57'(r0));
        rdy_en = 1'b1;
        for (int n = 0; n < 40000 && exec !== 1'b1; n++) @(posedge clk_i);
        repeat (40) @(posedge clk_i);
        #2;
        check_bit("exec_start", 1'b1, exec);
        check_val("exec_addr", 57'(EXEC_ADDR), 57'(exec_addr));
        check_bit("select_n", 1'b1, sel_n);
        check_bit("sck", 1'b0, sck);
        check_val("read command", 57'(CMD_READ), 57'(eep_u.cmd_word[15:8]));
        check_val("start address", 57'(START_ADDR), 57'(eep_u.cmd_word[7:0]));
        check_val("bit remainder", 57'h0, 57'(eep_u.rises % 8));
        check_val("write count", 57'(exp_q.size()), 57'(got_q.size()));
        foreach (exp_q[i]) begin
            if (i < got_q.size()) check_val("memory write", exp_q[i], got_q[i]);
        end
    endtask : boot_test
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #2400000;
        err_total++;
        $display("unexpected watchdog: expected finish, seen hang");
        print_verdict();
    end
    initial begin
        rst_i = 1'b1;
        mode_lo = 1'b0;
        mode_hi = 1'b0;
        ready = 1'b0;
        rdy_en = 1'b0;
        mode_off_test();
        boot_test();
        print_verdict();
    end
endmodule : sebl_loader_tb_top
`default_nettype wire
